//--- hdl/ipt_timing_core.sv
// Notes on behaviour
// - branches take one cycle, two if taken
// - halt-type ops wait for bus to drain
// - register group takes count plus one
// - multiply takes three to eighteen cycles
// - indirect subroutine call takes three cycles
// - control register moves take two cycles
// - register quartet transfer takes five cycles
// - loop decrements, updates carry, branches
// - all logical shifts take one cycle
// - nonzero byte test takes one cycle
// - inverted carry copy takes one cycle
// - divide takes three to thirty-seven cycles
`include "ipt_params.svh"
`default_nettype none

module ipt_timing_core
    import ipt_pkg::*;
(
    input  wire logic        clk_sys_in,       // System clock, 100 MHz
    input  wire logic        rstn_in,          // Async reset, active low
    input  wire logic        issue_valid_in,   // Instruction offered
    input  wire ipt_op_t     issue_op_in,      // Its class
    input  wire logic        branch_taken_in,  // Branch condition holds
    input  wire logic [4:0]  reg_count_in,     // Registers in a group
    input  wire logic [31:0] result_mag_in,    // Multiply/divide result size
    input  wire logic [31:0] loop_value_in,    // Loop register before update
    input  wire logic        mem_wait_in,      // Memory inserts a wait state
    input  wire logic        bus_busy_in,      // Bus transactions outstanding
    output logic             issue_ready_out,  // Issue accepted if offered this cycle
    output logic             done_out,         // Instruction completed
    output logic      [5:0]  cycles_out,       // Cycles it took
    output logic      [31:0] loop_value_out,   // Decremented loop register
    output logic             carry_out,        // Carry after loop update
    output logic             breakpoint_out,   // Breakpoint takes effect
    output logic             doze_out,         // Doze takes effect
    output logic             wait_out,         // Wait takes effect
    output logic             stop_out          // Stop takes effect
);

    // ****************************************
    // State
    // ****************************************
    ipt_state_t  state_reg, state_next;     // Sequencer
    ipt_op_t     op_reg, op_next;           // Class in flight
    logic [5:0]  left_reg, left_next;       // Cycles still to run
    logic [5:0]  cyc_reg, cyc_next;         // Cycles so far
    logic [5:0]  cycles_reg, cycles_next;   // Reported duration
    logic        done_reg, done_next;       // Completion pulse
    logic [31:0] loop_reg, loop_next;       // Loop register result
    logic        carry_reg, carry_next;     // Loop carry result
    logic [3:0]  fx_reg, fx_next;           // Effect pulses
    logic [5:0]  sig_w;                     // Result significance
    logic [5:0]  dur;                       // Duration of offered op
    logic        issue;                     // Issue accepted

    ipt_sig_width u_sig (
        .value_in  (result_mag_in),
        .width_out (sig_w)
    );

    assign issue_ready_out = (state_reg == IPT_ST_IDLE);
    assign issue           = issue_valid_in && issue_ready_out;

    // True for the four halt-type classes
    function automatic logic ipt_is_effect(input ipt_op_t op);
        return (op == IPT_OP_BREAKPOINT_OP) || (op == IPT_OP_DOZE) ||
               (op == IPT_OP_WAIT) || (op == IPT_OP_STOP);
    endfunction : ipt_is_effect

    // One-hot pulse pattern for a halt-type class
    function automatic logic [3:0] ipt_fx_code(input ipt_op_t op);
        case (op)
            IPT_OP_BREAKPOINT_OP: return 4'h1;
            IPT_OP_DOZE: return 4'h2;
            IPT_OP_WAIT: return 4'h4;
            IPT_OP_STOP: return 4'h8;
            default:     return 4'h0;
        endcase
    endfunction : ipt_fx_code

    // ****************************************
    // Duration of the offered instruction
    // ****************************************
    always_comb
    begin
        case (issue_op_in)
            // Taken branch costs a refetch
            IPT_OP_BRANCH, IPT_OP_LOOP:
                dur = branch_taken_in ? `IPT_CYC_BR_TAKEN : `IPT_CYC_BR_NOT;
            // Wait states are added while executing
            IPT_OP_LOAD, IPT_OP_STORE:
                dur = `IPT_CYC_LDST;
            IPT_OP_GROUP:
                dur = 6'({1'b0, reg_count_in} + 6'h01);
            IPT_OP_QUARTET:
                dur = `IPT_CYC_QUARTET;
            IPT_OP_CALL_IND:
                dur = `IPT_CYC_CALL_IND;
            IPT_OP_CTRL_MOVE:
                dur = `IPT_CYC_CTRL_MOVE;
            // Two result bits retired per cycle
            IPT_OP_MUL:
                dur = (`IPT_CYC_MUL_MIN + (sig_w >> 1) > `IPT_CYC_MUL_MAX) ?
                      `IPT_CYC_MUL_MAX : `IPT_CYC_MUL_MIN + (sig_w >> 1);
            // One quotient bit per cycle plus setup
            IPT_OP_DIV:
                dur = (sig_w == 6'h00) ? `IPT_CYC_DIV_MIN :
                      sig_w + `IPT_CYC_DIV_BASE;
            // Halt-type ops execute in one cycle
            IPT_OP_BREAKPOINT_OP, IPT_OP_DOZE, IPT_OP_WAIT, IPT_OP_STOP:
                dur = `IPT_CYC_EFFECT;
            // Shifts, byte test, carry copy
            default:
                dur = `IPT_CYC_SIMPLE;
        endcase
    end

    // ****************************************
    // Sequencer next state
    // ****************************************
    always_comb
    begin
        state_next  = state_reg;
        op_next     = op_reg;
        left_next   = left_reg;
        cyc_next    = cyc_reg;
        cycles_next = cycles_reg;
        done_next   = 1'b0;
        loop_next   = loop_reg;
        carry_next  = carry_reg;
        fx_next     = 4'h0;
        case (state_reg)
            IPT_ST_IDLE:
            begin
                if (issue)
                begin
                    op_next  = issue_op_in;
                    cyc_next = 6'h01;
                    if (issue_op_in == IPT_OP_LOOP)
                    begin
                        // Carry tells software the count is not yet spent
                        loop_next  = loop_value_in - 32'h0000_0001;
                        carry_next = (loop_value_in - 32'h0000_0001) != 32'h0;
                    end
                    if (ipt_is_effect(issue_op_in) && bus_busy_in)
                    begin
                        // Executed, but effect held until bus drains
                        state_next  = IPT_ST_HOLD;
                        cycles_next = `IPT_CYC_EFFECT;
                    end
                    else if (dur == 6'h01)
                    begin
                        done_next   = 1'b1;
                        cycles_next = 6'h01;
                        fx_next     = ipt_fx_code(issue_op_in);
                    end
                    else
                    begin
                        state_next = IPT_ST_EXEC;
                        left_next  = dur - 6'h01;
                    end
                end
            end
            IPT_ST_EXEC:
            begin
                cyc_next = cyc_reg + 6'h01;
                // Memory wait states stretch single transfers
                if (!(((op_reg == IPT_OP_LOAD) || (op_reg == IPT_OP_STORE)) && mem_wait_in))
                begin
                    left_next = left_reg - 6'h01;
                    if (left_reg == 6'h01)
                    begin
                        state_next  = IPT_ST_IDLE;
                        done_next   = 1'b1;
                        cycles_next = cyc_reg + 6'h01;
                    end
                end
            end
            IPT_ST_HOLD:
            begin
                // No issue accepted while the effect is pending
                if (!bus_busy_in)
                begin
                    state_next = IPT_ST_IDLE;
                    done_next  = 1'b1;
                    fx_next    = ipt_fx_code(op_reg);
                end
            end
            default:
            begin
                state_next = IPT_ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_reg  <= IPT_ST_IDLE;
            op_reg     <= IPT_OP_SIMPLE;
            left_reg   <= `IPT_RST_CYCLES;
            cyc_reg    <= `IPT_RST_CYCLES;
            cycles_reg <= `IPT_RST_CYCLES;
            done_reg   <= 1'b0;
            loop_reg   <= `IPT_RST_WORD;
            carry_reg  <= 1'b0;
            fx_reg     <= 4'h0;
        end
        else
        begin
            state_reg  <= state_next;
            op_reg     <= op_next;
            left_reg   <= left_next;
            cyc_reg    <= cyc_next;
            cycles_reg <= cycles_next;
            done_reg   <= done_next;
            loop_reg   <= loop_next;
            carry_reg  <= carry_next;
            fx_reg     <= fx_next;
        end
    end

    assign done_out       = done_reg;
    assign cycles_out     = cycles_reg;
    assign loop_value_out = loop_reg;
    assign carry_out      = carry_reg;
    assign breakpoint_out = fx_reg[0];
    assign doze_out       = fx_reg[1];
    assign wait_out       = fx_reg[2];
    assign stop_out       = fx_reg[3];

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    branch_not_taken_a: assert property (
        issue && issue_op_in == IPT_OP_BRANCH && !branch_taken_in
        |=> done_out && cycles_out == 6'h01)
        else $error("untaken branch not one cycle");

    branch_taken_a: assert property (
        issue && issue_op_in == IPT_OP_BRANCH && branch_taken_in
        |=> !done_out ##1 done_out && cycles_out == 6'h02)
        else $error("taken branch not two cycles");

    effect_drain_a: assert property (
        (breakpoint_out || doze_out || wait_out || stop_out) |-> $past(!bus_busy_in))
        else $error("effect while bus busy");

    // Group size kept from issue, so the check does not rely on the sequencer
    logic [4:0] grp_cnt_reg;
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            grp_cnt_reg <= 5'h00;
        end
        else if (issue)
        begin
            grp_cnt_reg <= reg_count_in;
        end
    end

    group_count_a: assert property (
        done_out && op_reg == IPT_OP_GROUP |-> cycles_out == {1'b0, grp_cnt_reg} + 6'h01)
        else $error("group duration wrong");

    mul_range_a: assert property (
        done_out && op_reg == IPT_OP_MUL |-> cycles_out inside {[6'h03:6'h12]})
        else $error("multiply out of range");

    call_ind_a: assert property (
        issue && issue_op_in == IPT_OP_CALL_IND |=> !done_out [*2] ##1 done_out)
        else $error("indirect call not three cycles");

    ctrl_move_a: assert property (
        issue && issue_op_in == IPT_OP_CTRL_MOVE |=> !done_out ##1 done_out)
        else $error("control move not two cycles");

    quartet_a: assert property (
        issue && issue_op_in == IPT_OP_QUARTET
        |=> !issue_ready_out [*4] ##1 done_out && cycles_out == 6'h05)
        else $error("quartet not five cycles");

    loop_update_a: assert property (
        issue && issue_op_in == IPT_OP_LOOP
        |=> loop_value_out == $past(loop_value_in) - 32'h1 &&
            carry_out == (loop_value_out != 32'h0))
        else $error("loop update wrong");

    simple_one_a: assert property (
        issue && issue_op_in == IPT_OP_SIMPLE |=> done_out && issue_ready_out)
        else $error("simple op not one cycle");

    div_range_a: assert property (
        done_out && op_reg == IPT_OP_DIV |-> cycles_out inside {[6'h03:6'h25]})
        else $error("divide out of range");

    ldst_floor_a: assert property (
        issue && issue_op_in == IPT_OP_LOAD && !mem_wait_in
        ##1 !mem_wait_in |=> done_out && cycles_out == 6'h02)
        else $error("load without waits not two cycles");

    hold_cov_c:   cover property (issue && ipt_is_effect(issue_op_in) && bus_busy_in);
    div_long_c:   cover property (done_out && op_reg == IPT_OP_DIV && cycles_out > 6'h20);
    ldst_wait_c:  cover property (state_reg == IPT_ST_EXEC && op_reg == IPT_OP_LOAD
                                  && mem_wait_in);
    back_to_back_c: cover property (done_out && issue);

endmodule : ipt_timing_core

`default_nettype wire

//--- inc/ipt_params.svh
`ifndef IPT_PARAMS_SVH
`define IPT_PARAMS_SVH

// ****************************************
// Execution cycle counts per class
// ****************************************
`define IPT_CYC_SIMPLE      6'h01
`define IPT_CYC_BR_NOT      6'h01
`define IPT_CYC_BR_TAKEN    6'h02
`define IPT_CYC_LDST        6'h02
`define IPT_CYC_CALL_IND    6'h03
`define IPT_CYC_CTRL_MOVE   6'h02
`define IPT_CYC_QUARTET     6'h05
`define IPT_CYC_EFFECT      6'h01
`define IPT_CYC_MUL_MIN     6'h03
`define IPT_CYC_MUL_MAX     6'h12
`define IPT_CYC_DIV_MIN     6'h03
`define IPT_CYC_DIV_MAX     6'h25
`define IPT_CYC_DIV_BASE    6'h05

// ****************************************
// Reset values
// ****************************************
`define IPT_RST_CYCLES      6'h00
`define IPT_RST_WORD        32'h0000_0000

`endif

//--- inc/ipt_pkg.sv
`default_nettype none

package ipt_pkg;

    // ****************************************
    // Instruction classes seen by the timer
    // ****************************************
    typedef enum logic [3:0] {
        IPT_OP_SIMPLE    = 4'h0, // Shifts, byte test, carry copy
        IPT_OP_BRANCH    = 4'h1, // Conditional and plain branches
        IPT_OP_LOOP      = 4'h2, // loop_decrement_branch
        IPT_OP_LOAD      = 4'h3, // single_load_op, relative word
        IPT_OP_STORE     = 4'h4, // single_store_op
        IPT_OP_GROUP     = 4'h5, // load/store_register_group
        IPT_OP_QUARTET   = 4'h6, // load/store_register_quartet
        IPT_OP_CALL_IND  = 4'h7, // indirect_subroutine_call
        IPT_OP_CTRL_MOVE = 4'h8, // read/write_control_reg_op
        IPT_OP_MUL       = 4'h9, // multiply_op
        IPT_OP_DIV       = 4'ha, // Signed and unsigned_divide_op
        IPT_OP_BREAKPOINT_OP      = 4'hb, // breakpoint_op
        IPT_OP_DOZE      = 4'hc,
        IPT_OP_WAIT      = 4'hd,
        IPT_OP_STOP      = 4'he
    } ipt_op_t;

    // ****************************************
    // Sequencer states, one-hot
    // ****************************************
    typedef enum logic [2:0] {
        IPT_ST_IDLE = 3'b001, // Ready for issue
        IPT_ST_EXEC = 3'b010, // Multi-cycle execution
        IPT_ST_HOLD = 3'b100  // Effect waits for bus to drain
    } ipt_state_t;

endpackage : ipt_pkg

`default_nettype wire

//--- hdl/ipt_sig_width.sv
`default_nettype none

// ****************************************
// Significant bit count of a result
// ****************************************
module ipt_sig_width
    import ipt_pkg::*;
(
    input  wire logic [31:0] value_in,  // Result magnitude
    output logic      [5:0]  width_out  // 0 when value is zero
);

    // Position of the highest set bit plus one
    function automatic logic [5:0] ipt_msb_width(input logic [31:0] v);
        logic [5:0] w;
        w = 6'h00;
        for (int i = 0; i < 32; i++)
        begin
            if (v[i])
            begin
                w = 6'(i + 1);
            end
        end
        return w;
    endfunction : ipt_msb_width

    // Pure decode, no state
    always_comb
    begin
        width_out = ipt_msb_width(value_in);
    end

endmodule : ipt_sig_width

`default_nettype wire

//--- verif/ipt_bus_model.sv
`default_nettype none

// ****************************************
// Memory and bus side of the core
// ****************************************
module ipt_bus_model
(
    input  wire logic       clk_sys_in,    // System clock
    input  wire logic       rstn_in,       // Async reset, active low
    input  wire logic       arm_in,        // Bench arms a new transfer
    input  wire logic [3:0] wait_count_in, // Wait states for the next access
    input  wire logic [3:0] busy_count_in, // Cycles the bus stays busy
    output logic            mem_wait_out,  // Wait state this cycle
    output logic            bus_busy_out   // Transactions outstanding
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_cnt_reg; // Wait states still to insert
    logic [3:0] busy_cnt_reg; // Busy cycles still to show

    // Counters load on arm, then run down one per cycle
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wait_cnt_reg <= 4'h0;
            busy_cnt_reg <= 4'h0;
        end
        else if (arm_in)
        begin
            wait_cnt_reg <= wait_count_in;
            busy_cnt_reg <= (busy_count_in == 4'h0) ? 4'h0 : busy_count_in - 4'h1;
        end
        else
        begin
            wait_cnt_reg <= (wait_cnt_reg == 4'h0) ? 4'h0 : wait_cnt_reg - 4'h1;
            busy_cnt_reg <= (busy_cnt_reg == 4'h0) ? 4'h0 : busy_cnt_reg - 4'h1;
        end
    end

    // Waits begin the cycle after the access is issued
    assign mem_wait_out = (wait_cnt_reg != 4'h0);
    // Busy is already seen in the issue cycle, so a halt op must hold
    assign bus_busy_out = (busy_cnt_reg != 4'h0) || (arm_in && busy_count_in != 4'h0);
endmodule : ipt_bus_model

`default_nettype wire

//--- verif/test_cpu_instruction_timing.sv
`default_nettype none

module test_cpu_instruction_timing;
    import ipt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Stimulus, wires and score
    // ****************************************
    logic        clk_sys_in      = 1'b0;
    logic        rstn_in         = 1'b0;
    logic        issue_valid_in  = 1'b0;
    ipt_op_t     issue_op_in     = IPT_OP_SIMPLE;
    logic        branch_taken_in = 1'b0;
    logic [4:0]  reg_count_in    = 5'h01;
    logic [31:0] result_mag_in   = 32'h0;
    logic [31:0] loop_value_in   = 32'h0;
    logic        arm_in          = 1'b0; // Arms the bus model
    logic [3:0]  wait_count_in   = 4'h0;
    logic [3:0]  busy_count_in   = 4'h0;
    wire logic   mem_wait_in;
    wire logic   bus_busy_in;
    logic        issue_ready_out;
    logic        done_out;
    logic [5:0]  cycles_out;
    logic [31:0] loop_value_out;
    logic        carry_out;
    logic        breakpoint_out;
    logic        doze_out;
    logic        wait_out;
    logic        stop_out;
    int          fails        = 0;
    int          total_checks = 0;
    logic [31:0] exp_loop     = 32'h0; // Model of the loop register
    logic        exp_carry    = 1'b0;
    int          k;
    int          j;
    int          seed_ret;

    always #5 clk_sys_in = ~clk_sys_in;

    ipt_timing_core u_dut (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .issue_valid_in(issue_valid_in),
        .issue_op_in(issue_op_in), .branch_taken_in(branch_taken_in),
        .reg_count_in(reg_count_in), .result_mag_in(result_mag_in),
        .loop_value_in(loop_value_in), .mem_wait_in(mem_wait_in),
        .bus_busy_in(bus_busy_in), .issue_ready_out(issue_ready_out),
        .done_out(done_out), .cycles_out(cycles_out), .loop_value_out(loop_value_out),
        .carry_out(carry_out), .breakpoint_out(breakpoint_out), .doze_out(doze_out),
        .wait_out(wait_out), .stop_out(stop_out));

    ipt_bus_model u_bus (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .arm_in(arm_in),
        .wait_count_in(wait_count_in), .busy_count_in(busy_count_in),
        .mem_wait_out(mem_wait_in), .bus_busy_out(bus_busy_in));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("Checks made %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // Reset from a falling edge; outputs checked in and after reset
    task automatic apply_reset;
        rstn_in = 1'b0;
        issue_valid_in = 1'b0;
        arm_in = 1'b0;
        #1;
        check("ready_in_reset", 32'(issue_ready_out), 32'h1);
        repeat (8) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rstn_in = 1'b1;
        exp_loop = 32'h0;
        exp_carry = 1'b0;
        check("outputs_after_reset", 32'({done_out, cycles_out, carry_out, breakpoint_out,
              doze_out, wait_out, stop_out, issue_ready_out}), 32'h001);
        check("loop_after_reset", loop_value_out, 32'h0);
    endtask : apply_reset

    // Issue one op at a falling edge and time it; leaves valid high
    task automatic run_op(input ipt_op_t op, input logic taken, input logic [4:0] cnt,
                          input logic [31:0] mag, input logic [31:0] lv,
                          input int waits, input int busy);
        int w;
        int d;
        int c;
        int n;
        logic [3:0] eff;
        w = 0;
        for (int b = 0; b < 32; b++)
            if (mag[b])
                w = b + 1;
        eff = 4'h0;
        c = 0;
        case (op)
            IPT_OP_BRANCH, IPT_OP_LOOP: d = taken ? 2 : 1;
            IPT_OP_LOAD, IPT_OP_STORE:  d = 2 + waits;
            IPT_OP_GROUP:               d = int'(cnt) + 1;
            IPT_OP_QUARTET:             d = 5;
            IPT_OP_CALL_IND:            d = 3;
            IPT_OP_CTRL_MOVE:           d = 2;
            IPT_OP_MUL:                 d = (3 + w / 2 > 18) ? 18 : 3 + w / 2;
            IPT_OP_DIV:                 d = (w == 0) ? 3 : w + 5;
            IPT_OP_BREAKPOINT_OP, IPT_OP_DOZE, IPT_OP_WAIT, IPT_OP_STOP:
            begin
                d = busy + 1;
                c = 1;
                eff = 4'h8 >> (int'(op) - int'(IPT_OP_BREAKPOINT_OP));
            end
            default:                    d = 1;
        endcase
        if (c == 0)
            c = d;
        issue_valid_in = 1'b1;
        issue_op_in = op;
        branch_taken_in = taken;
        reg_count_in = cnt;
        result_mag_in = mag;
        loop_value_in = lv;
        arm_in = 1'b1;
        wait_count_in = 4'(waits);
        busy_count_in = 4'(busy);
        for (n = 1; n < 64; n++)
        begin
            @(posedge clk_sys_in);
            @(negedge clk_sys_in);
            arm_in = 1'b0;
            if (done_out === 1'b1)
                break;
            check("ready_while_busy", 32'(issue_ready_out), 32'h0);
            check("effect_early", 32'({breakpoint_out, doze_out, wait_out, stop_out}), 32'h0);
            // Junk offered while busy must be refused
            issue_op_in = ipt_op_t'($urandom_range(0, 14));
            result_mag_in = $urandom;
            loop_value_in = $urandom;
            reg_count_in = 5'($urandom_range(1, 16));
        end
        if (n >= 64)
        begin
            fails++;
            $display("FAIL done_wait expected done seen none");
            tally_and_finish();
        end
        if (op == IPT_OP_LOOP)
        begin
            exp_loop = lv - 32'h1;
            exp_carry = (exp_loop != 32'h0);
        end
        check("duration", 32'(n), 32'(d));
        check("cycles_out", 32'(cycles_out), 32'(c));
        check("ready_at_done", 32'(issue_ready_out), 32'h1);
        check("effects", 32'({breakpoint_out, doze_out, wait_out, stop_out}), 32'(eff));
        check("loop_value", loop_value_out, exp_loop);
        check("loop_carry", 32'(carry_out), 32'(exp_carry));
    endtask : run_op

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        seed_ret = $urandom(32'h3c8a);
        @(negedge clk_sys_in);
        apply_reset();
        $display("test reset done");
        // Every class with boundary counts, magnitudes, waits and busy spans
        for (k = 0; k < 15; k++)
            for (j = 0; j < 4; j++)
                run_op(ipt_op_t'(k), j[0], 5'(j * 5 + 1),
                       (j == 0) ? 32'h0 : (j == 1) ? 32'hffff_ffff : (j == 2) ? 32'h1 : $urandom,
                       (j == 0) ? 32'h1 : (j == 1) ? 32'h0 : $urandom, j, j);
        $display("test class table done");
        // Random back-to-back traffic
        for (k = 0; k < 60; k++)
            run_op(ipt_op_t'($urandom_range(0, 14)), 1'($urandom), 5'($urandom_range(1, 16)),
                   $urandom >> $urandom_range(0, 31), $urandom,
                   $urandom_range(0, 3), $urandom_range(0, 3));
        $display("test random traffic done");
        // Reset in the middle of a long multiply
        issue_op_in = IPT_OP_MUL;
        result_mag_in = 32'hffff_ffff;
        @(negedge clk_sys_in);
        issue_valid_in = 1'b0;
        @(negedge clk_sys_in);
        apply_reset();
        run_op(IPT_OP_STOP, 1'b0, 5'h01, 32'h0, 32'h0, 0, 0);
        issue_valid_in = 1'b0;
        @(negedge clk_sys_in);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule : test_cpu_instruction_timing

`default_nettype wire
